// ---- bench/autoneg_chk.sv ----
// Port-level assertions for the negotiation monitor.
// Assumes one clock, mclk, and synchronous resets srst and softReset.
`timescale 1ns/10ps
`default_nettype none
module autoneg_chk
  import autoneg_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic softReset,
  // Inputs
  input wire logic softwareMode,
  input wire logic negotiationEnable,
  input wire logic restartWrite,
  input wire logic detailedStatusRead,
  input wire logic [ABIL_W-1:0] localAdvert,
  input wire logic linkUp,
  input wire logic localLinkFault,
  input wire logic partnerPageValid,
  input wire logic [ABIL_W-1:0] partnerPage,
  input wire logic partnerAck,
  input wire logic nlpSeen,
  input wire logic idle100Seen,
  // Outputs
  input wire logic restartPending,
  input wire logic negotiationComplete,
  input wire logic completeMirror,
  input wire logic remoteFaultDetected,
  input wire logic parallelDetectFault,
  input wire logic [PROG_W-1:0] progressStatus,
  input wire arb_state_t arbState,
  input wire logic [ABIL_W-1:0] flpWord
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || softReset);
  logic go;
  assign go = negotiationEnable && !restartPending;

  reset_idle_a: assert property (disable iff (1'b0)
    srst || softReset |=> arbState == ARB_IDLE && progressStatus == 3'h0)
    else $error("reset left monitor busy");
  fault_seen_a: assert property (arbState == ARB_ABILITY && go &&
    partnerPageValid && partnerPage[BIT_REMOTE_FAULT] |=> remoteFaultDetected)
    else $error("partner fault missed");
  flp_fault_a: assert property (1'b1 |=> flpWord ==
    $past(localAdvert | (ABIL_W'(localLinkFault) << BIT_REMOTE_FAULT)))
    else $error("advert word wrong");
  restart_run_a: assert property (restartPending && softwareMode &&
    !restartWrite |=> arbState == ARB_IDLE && !restartPending)
    else $error("restart not run");
  prog_mono_a: assert property (!detailedStatusRead |=>
    progressStatus >= $past(progressStatus))
    else $error("progress went down");
  prog_hold_a: assert property (progressStatus == PROG_COMPLETE &&
    !detailedStatusRead |=> progressStatus == PROG_COMPLETE)
    else $error("completed progress not held");
  complete_bits_a: assert property (arbState == ARB_ACK && partnerAck && go
    |=> negotiationComplete && completeMirror)
    else $error("completion bits missing");
  link_fail_a: assert property (arbState == ARB_COMPLETE && go &&
    $fell(linkUp) |=> arbState == ARB_IDLE)
    else $error("link loss not restarted");
  par_fault_a: assert property (arbState == ARB_ABILITY && go &&
    nlpSeen && idle100Seen && !partnerPageValid |=> parallelDetectFault)
    else $error("parallel fault missed");

  cover property (arbState == ARB_COMPLETE && !nlpSeen);
  cover property (parallelDetectFault);
  cover property (restartPending && !softwareMode);
endmodule : autoneg_chk

bind autoneg_fault_restart_monitor autoneg_chk autoneg_chk_inst (
  .mclk(mclk), .srst(srst), .softReset(softReset),
  .softwareMode(softwareMode), .negotiationEnable(negotiationEnable),
  .restartWrite(restartWrite), .detailedStatusRead(detailedStatusRead),
  .localAdvert(localAdvert), .linkUp(linkUp), .localLinkFault(localLinkFault),
  .partnerPageValid(partnerPageValid), .partnerPage(partnerPage),
  .partnerAck(partnerAck), .nlpSeen(nlpSeen), .idle100Seen(idle100Seen),
  .restartPending(restartPending), .completeMirror(completeMirror),
  .negotiationComplete(negotiationComplete), .arbState(arbState),
  .remoteFaultDetected(remoteFaultDetected), .flpWord(flpWord),
  .parallelDetectFault(parallelDetectFault), .progressStatus(progressStatus)
);
`default_nettype wire

// ---- bench/autoneg_fault_restart_monitor_tb.sv ----
// Self-checking bench for the negotiation monitor.
// Assumes a short negotiation timeout of 50 cycles.
`timescale 1ns/10ps
`default_nettype none
module autoneg_fault_restart_monitor_tb;
  import autoneg_pkg::*;
  logic mclk = 0, srst = 1, softReset = 0, softwareMode = 1;
  logic negotiationEnable = 1, restartWrite = 0, detailedStatusRead = 0;
  logic linkUp = 1, localLinkFault = 0, sendPage = 0, sendAck = 0;
  logic [15:0] localAdvert = 16'h03e0, word = 16'h0000;
  logic [1:0] legacy = 2'h0;
  logic partnerPageValid, partnerAck, nlpSeen, idle100Seen;
  logic restartPending, negotiationComplete, completeMirror;
  logic remoteFaultDetected, parallelDetectFault, partner_negotiation_capable;
  logic negotiationOverdue, remoteFaultMirror;
  logic [15:0] partnerPage, partnerAbility, flpWord;
  logic [2:0] progressStatus;
  op_mode_t resolvedMode;
  arb_state_t arbState;
  int fails = 0, check_count = 0;

  always #12.5 mclk = ~mclk;

  link_partner_model link_partner_model_inst (.sendPage(sendPage),
    .sendAck(sendAck), .word(word), .legacy(legacy),
    .partnerPageValid(partnerPageValid), .partnerPage(partnerPage),
    .partnerAck(partnerAck), .nlpSeen(nlpSeen), .idle100Seen(idle100Seen));

  autoneg_fault_restart_monitor #(.TIMEOUT_CYCLES(50))
    autoneg_fault_restart_monitor_inst (.mclk(mclk), .srst(srst),
    .softReset(softReset), .softwareMode(softwareMode),
    .negotiationEnable(negotiationEnable), .restartWrite(restartWrite),
    .detailedStatusRead(detailedStatusRead), .localAdvert(localAdvert),
    .linkUp(linkUp), .localLinkFault(localLinkFault),
    .partnerPageValid(partnerPageValid), .partnerPage(partnerPage),
    .partnerAck(partnerAck), .nlpSeen(nlpSeen), .idle100Seen(idle100Seen),
    .restartPending(restartPending), .completeMirror(completeMirror),
    .negotiationComplete(negotiationComplete), .flpWord(flpWord),
    .remoteFaultDetected(remoteFaultDetected),
    .remoteFaultMirror(remoteFaultMirror),
    .parallelDetectFault(parallelDetectFault), .resolvedMode(resolvedMode),
    .partner_negotiation_capable(partner_negotiation_capable),
    .partnerAbility(partnerAbility), .progressStatus(progressStatus),
    .arbState(arbState), .negotiationOverdue(negotiationOverdue));

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task rst;
    srst = 1;
    cyc(5);
    srst = 0;
    cyc(1);
    chk(arbState, ARB_ABILITY);
  endtask : rst

  task nego(input logic [15:0] w);
    word = w;
    sendPage = 1;
    cyc(1);
    sendPage = 0;
    sendAck = 1;
    cyc(1);
    sendAck = 0;
    cyc(1);
  endtask : nego

  task t_modes;
    logic [15:0] w [5];
    op_mode_t m [5];
    w = '{16'h2100, 16'h00e0, 16'h0060, 16'h0020, 16'h0200};
    m = '{MODE_100_FULL, MODE_100_HALF, MODE_10_FULL, MODE_10_HALF, MODE_NONE};
    rst;
    for (int i = 0; i < 5; i++) begin
      if (i > 0) begin
        restartWrite = 1;
        cyc(1);
        restartWrite = 0;
        cyc(2);
        chk(progressStatus, PROG_COMPLETE);
        detailedStatusRead = 1;
        cyc(1);
        detailedStatusRead = 0;
        chk(progressStatus, PROG_ABILITY);
      end
      nego(w[i]);
      chk(resolvedMode, m[i]);
      chk(remoteFaultDetected, w[i][13]);
      chk(remoteFaultMirror, w[i][13]);
      chk(partnerAbility, w[i]);
      chk(negotiationComplete & completeMirror, 1'b1);
      chk(progressStatus, PROG_COMPLETE);
    end
    $display("modes done");
  endtask : t_modes

  task t_par;
    for (int i = 1; i < 4; i++) begin
      rst;
      legacy = i[1:0];
      cyc(2);
      chk(parallelDetectFault, i == 3);
      if (i < 3) begin
        chk(partnerAbility, i == 1 ? 16'h0020 : 16'h0080);
        chk(partner_negotiation_capable, 1'b0);
        chk(negotiationComplete, 1'b1);
        chk(negotiationComplete & linkUp, 1'b1);
        linkUp = 0;
        cyc(1);
        chk(arbState, ARB_IDLE);
        linkUp = 1;
      end
      legacy = 0;
    end
    $display("parallel done");
  endtask : t_par

  task t_fault;
    localLinkFault = 1;
    cyc(2);
    chk(flpWord, localAdvert | 16'h2000);
    localLinkFault = 0;
    cyc(2);
    chk(flpWord, localAdvert);
    $display("fault done");
  endtask : t_fault

  task t_ctl;
    rst;
    nego(16'h0100);
    softwareMode = 0;
    restartWrite = 1;
    cyc(1);
    restartWrite = 0;
    cyc(2);
    chk(arbState, ARB_COMPLETE);
    chk(restartPending, 1'b1);
    softwareMode = 1;
    cyc(2);
    chk(restartPending, 1'b0);
    nego(16'h0100);
    negotiationEnable = 0;
    cyc(2);
    negotiationEnable = 1;
    cyc(2);
    chk(arbState, ARB_ABILITY);
    cyc(40);
    chk(negotiationOverdue, 1'b0);
    // The overdue flag stands only for the cycle of the timeout restart
    cyc(10);
    chk(negotiationOverdue, 1'b1);
    chk(arbState, ARB_IDLE);
    softReset = 1;
    cyc(1);
    chk(progressStatus, PROG_IDLE);
    chk(arbState, ARB_IDLE);
    softReset = 0;
    $display("control done");
  endtask : t_ctl

  task results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    t_modes;
    t_par;
    t_fault;
    t_ctl;
    results;
  end

  // Tests need about 140 cycles; 50 us leaves ample margin
  initial begin
    #50us;
    fails++;
    results;
  end
endmodule : autoneg_fault_restart_monitor_tb
`default_nettype wire

// ---- bench/link_partner_model.sv ----
// Behavioural link partner: turns bench commands into link-side events.
// Assumes the bench changes commands only at falling edges of mclk.
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
  // Commands
  input wire logic sendPage,
  input wire logic sendAck,
  input wire logic [15:0] word,
  input wire logic [1:0] legacy,
  // Link side
  output logic partnerPageValid,
  output logic [15:0] partnerPage,
  output logic partnerAck,
  output logic nlpSeen,
  output logic idle100Seen
);
  always_comb begin
    partnerPageValid = sendPage;
    // Junk outside the strobe, so a stale word is never trusted
    partnerPage = sendPage ? word : ~word;
    partnerAck = sendAck;
    nlpSeen = legacy[0];
    idle100Seen = legacy[1];
  end
endmodule : link_partner_model
`default_nettype wire

// ---- verilog/autoneg_fault_restart_monitor.sv ----
// Negotiation arbitration, restart control, progress monitor and fault
// reporting. Assumes all inputs are synchronous to mclk and that pulse
// inputs last one cycle.
//
// Notes on behaviour
// - Partner fault in received advertisement sets the remote-fault-detected outputs.
// - Own link fault sets the remote-fault bit of the transmitted advertisement.
// - With negotiation enabled, run negotiation after power-up and on request.
// - Every reset returns arbitration and progress monitor to idle.
// - Every reset clears the progress-monitor status bits.
// - Restart returns arbitration to idle but keeps progress status bits.
// - Progress status changes only on read, reset or arbitration advancing.
// - Otherwise progress status updates only to a strictly greater code.
// - After completion, progress status holds until detailed read or reset.
// - A link failure restarts negotiation.
// - Software writing restart bit restarts negotiation; bit clears itself.
// - Software toggling enable one-zero-one restarts negotiation.
// - Negotiation normally finishes within 500 ms.
// - Mode priority: 100 full, 100 half, 10 full, 10 half; T4 unsupported.
// - On completion set basic and mirrored completion bits.
// - Multiple technologies sensed in parallel detection set a fault bit.
// - Transmitted pulse-burst content comes from the local advertisement.
`timescale 1ns/10ps
`default_nettype none
module autoneg_fault_restart_monitor
  import autoneg_pkg::*;
#(
  parameter longint TIMEOUT_CYCLES = NEG_LIMIT_CYCLES
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic softReset,
  // Management control
  input wire logic softwareMode,
  input wire logic negotiationEnable,
  input wire logic restartWrite,
  input wire logic detailedStatusRead,
  input wire logic [ABIL_W-1:0] localAdvert,
  // Link side events
  input wire logic linkUp,
  input wire logic localLinkFault,
  input wire logic partnerPageValid,
  input wire logic [ABIL_W-1:0] partnerPage,
  input wire logic partnerAck,
  input wire logic nlpSeen,
  input wire logic idle100Seen,
  // Status
  output logic restartPending,
  output logic negotiationComplete,
  output logic completeMirror,
  output logic remoteFaultDetected,
  output logic remoteFaultMirror,
  output logic parallelDetectFault,
  output logic partner_negotiation_capable,
  output logic [ABIL_W-1:0] partnerAbility,
  output var op_mode_t resolvedMode,
  output logic [PROG_W-1:0] progressStatus,
  output var arb_state_t arbState,
  output logic negotiationOverdue,
  // Transmit advertisement word
  output logic [ABIL_W-1:0] flpWord
);

  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (64'd1 << TIMER_W)) begin : g_chk
    $error("TIMEOUT_CYCLES out of range for the negotiation timer");
  end

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);

  function automatic logic [PROG_W-1:0] progressCode(input arb_state_t s);
    unique case (s)
      ARB_IDLE: progressCode = PROG_IDLE;
      ARB_ABILITY: progressCode = PROG_ABILITY;
      ARB_PARALLEL: progressCode = PROG_PARALLEL;
      ARB_ACK: progressCode = PROG_ACK;
      ARB_COMPLETE: progressCode = PROG_COMPLETE;
    endcase
  endfunction : progressCode

  logic anyReset;
  logic linkFail;
  logic toggleRestart;
  logic timeout;
  logic restartNow;
  logic linkUpPrev;
  logic enablePrev;
  logic toggleArmed;
  logic [TIMER_W-1:0] timer;
  op_mode_t bestMode;

  arb_state_t next_arbState;
  logic [ABIL_W-1:0] next_partnerAbility;
  logic next_capable;
  logic next_parallelFault;
  logic next_complete;
  op_mode_t next_resolvedMode;
  logic [PROG_W-1:0] next_progressStatus;
  logic next_restartPending;
  logic next_toggleArmed;
  logic [TIMER_W-1:0] next_timer;
  logic next_overdue;
  logic [ABIL_W-1:0] next_flpWord;
  logic next_remoteFault;

  mode_resolver u_resolver (
    .localAbility(localAdvert),
    .partnerAbility(partnerAbility),
    .mode(bestMode)
  );

  // Restart sources
  always_comb begin
    anyReset = srst | softReset;
    linkFail = linkUpPrev & ~linkUp & (arbState == ARB_COMPLETE);
    toggleRestart = softwareMode & toggleArmed & negotiationEnable
      & ~enablePrev;
    timeout = (timer == TIMER_LAST) && (arbState != ARB_IDLE)
      && (arbState != ARB_COMPLETE);
    restartNow = linkFail | toggleRestart | timeout
      | (softwareMode & restartPending);
  end

  // Control bit bookkeeping: a new write wins over the self-clear
  always_comb begin
    next_restartPending = restartWrite
      | (restartPending & ~softwareMode);
    next_toggleArmed = toggleArmed;
    if (enablePrev & ~negotiationEnable) begin
      next_toggleArmed = 1'b1;
    end else if (toggleRestart) begin
      next_toggleArmed = 1'b0;
    end
    next_flpWord = localAdvert;
    next_flpWord[BIT_REMOTE_FAULT] = localAdvert[BIT_REMOTE_FAULT]
      | localLinkFault;
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      restartPending <= 1'b0;
      toggleArmed <= 1'b0;
      enablePrev <= 1'b0;
      linkUpPrev <= 1'b0;
      flpWord <= ABIL_RESET;
    end else begin
      restartPending <= next_restartPending;
      toggleArmed <= next_toggleArmed;
      enablePrev <= negotiationEnable;
      linkUpPrev <= linkUp;
      flpWord <= next_flpWord;
    end
  end

  // Arbitration state machine
  always_comb begin
    next_arbState = arbState;
    next_partnerAbility = partnerAbility;
    next_capable = partner_negotiation_capable;
    next_parallelFault = parallelDetectFault;
    next_complete = negotiationComplete;
    next_resolvedMode = resolvedMode;
    next_timer = timer + TIMER_W'(1);
    next_overdue = negotiationOverdue | timeout;
    if (restartNow || !negotiationEnable) begin
      next_arbState = ARB_IDLE;
      next_complete = 1'b0;
      next_timer = '0;
    end else begin
      unique case (arbState)
        ARB_IDLE: begin
          next_arbState = ARB_ABILITY;
          next_timer = '0;
          next_parallelFault = 1'b0;
          next_overdue = 1'b0;
        end
        ARB_ABILITY: begin
          if (partnerPageValid) begin
            next_partnerAbility = partnerPage;
            next_capable = 1'b1;
            next_arbState = ARB_ACK;
          end else if (nlpSeen && idle100Seen) begin
            next_parallelFault = 1'b1;
          end else if (nlpSeen) begin
            next_partnerAbility = ABIL_RESET;
            next_partnerAbility[BIT_10_HALF] = 1'b1;
            next_capable = 1'b0;
            next_arbState = ARB_PARALLEL;
          end else if (idle100Seen) begin
            next_partnerAbility = ABIL_RESET;
            next_partnerAbility[BIT_100_HALF] = 1'b1;
            next_capable = 1'b0;
            next_arbState = ARB_PARALLEL;
          end
        end
        ARB_PARALLEL: begin
          next_arbState = ARB_COMPLETE;
          next_complete = 1'b1;
          next_resolvedMode = bestMode;
        end
        ARB_ACK: begin
          if (partnerAck) begin
            next_arbState = ARB_COMPLETE;
            next_complete = 1'b1;
            next_resolvedMode = bestMode;
          end
        end
        ARB_COMPLETE: begin
          next_timer = timer;
        end
      endcase
    end
    next_remoteFault = next_partnerAbility[BIT_REMOTE_FAULT];
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      arbState <= ARB_IDLE;
      partnerAbility <= ABIL_RESET;
      partner_negotiation_capable <= 1'b0;
      parallelDetectFault <= 1'b0;
      negotiationComplete <= 1'b0;
      resolvedMode <= MODE_NONE;
      timer <= '0;
      negotiationOverdue <= 1'b0;
      remoteFaultDetected <= 1'b0;
    end else begin
      arbState <= next_arbState;
      partnerAbility <= next_partnerAbility;
      partner_negotiation_capable <= next_capable;
      parallelDetectFault <= next_parallelFault;
      negotiationComplete <= next_complete;
      resolvedMode <= next_resolvedMode;
      timer <= next_timer;
      negotiationOverdue <= next_overdue;
      remoteFaultDetected <= next_remoteFault;
    end
  end

  always_comb begin
    completeMirror = negotiationComplete;
    remoteFaultMirror = remoteFaultDetected;
  end

  // Progress monitor: a read reloads the live code, otherwise only climbs.
  // Complete is the top code, so it is held naturally until read/reset.
  always_comb begin
    next_progressStatus = progressStatus;
    if (detailedStatusRead) begin
      next_progressStatus = progressCode(arbState);
    end else if (progressStatus != PROG_COMPLETE
        && progressCode(arbState) > progressStatus) begin
      next_progressStatus = progressCode(arbState);
    end
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      progressStatus <= PROG_IDLE;
    end else begin
      progressStatus <= next_progressStatus;
    end
  end

endmodule : autoneg_fault_restart_monitor
`default_nettype wire

// ---- verilog/autoneg_pkg.sv ----
// Shared constants and types for the negotiation fault/restart monitor.
// Assumes a single 40 MHz core clock; no bus, all bits are plain ports.
package autoneg_pkg;

  // Ability word field positions (advertisement and partner words)
  localparam int ABIL_W = 16;
  localparam int BIT_10_HALF = 5;
  localparam int BIT_10_FULL = 6;
  localparam int BIT_100_HALF = 7;
  localparam int BIT_100_FULL = 8;
  localparam int BIT_T4 = 9;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam logic [15:0] ABIL_RESET = 16'h0000;

  // Progress monitor encoding, strictly increasing with progress
  localparam int PROG_W = 3;
  localparam logic [2:0] PROG_IDLE = 3'h0;
  localparam logic [2:0] PROG_ABILITY = 3'h1;
  localparam logic [2:0] PROG_PARALLEL = 3'h2;
  localparam logic [2:0] PROG_ACK = 3'h3;
  localparam logic [2:0] PROG_COMPLETE = 3'h4;

  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint NEG_LIMIT_MS = 500;
  localparam longint NEG_LIMIT_CYCLES = (NEG_LIMIT_MS * CLK_HZ) / 1000;
  localparam int TIMER_W = 25;

  typedef enum logic [2:0] {
    ARB_IDLE,
    ARB_ABILITY,
    ARB_PARALLEL,
    ARB_ACK,
    ARB_COMPLETE
  } arb_state_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_100_FULL,
    MODE_100_HALF,
    MODE_10_FULL,
    MODE_10_HALF
  } op_mode_t;

endpackage : autoneg_pkg

// ---- verilog/mode_resolver.sv ----
// Picks the best operating mode common to two ability words.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module mode_resolver
  import autoneg_pkg::*;
(
  // Ability words
  input wire logic [ABIL_W-1:0] localAbility,
  input wire logic [ABIL_W-1:0] partnerAbility,
  // Result
  output var op_mode_t mode
);

  logic [ABIL_W-1:0] common;

  // T4 ranks second but is never chosen, so it is simply skipped
  always_comb begin
    common = localAbility & partnerAbility;
    if (common[BIT_100_FULL]) begin
      mode = MODE_100_FULL;
    end else if (common[BIT_100_HALF]) begin
      mode = MODE_100_HALF;
    end else if (common[BIT_10_FULL]) begin
      mode = MODE_10_FULL;
    end else if (common[BIT_10_HALF]) begin
      mode = MODE_10_HALF;
    end else begin
      mode = MODE_NONE;
    end
  end

endmodule : mode_resolver
`default_nettype wire
